// ---- angle_port_pkg.sv ----
package angle_port_pkg;

  // Counter width: MSB weighs half a turn, LSB one 4096th of a turn
  localparam int ANGLE_W = 12;
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 12'h000;
  localparam logic [ANGLE_W-1:0] ANGLE_ALL_ONES = 12'hfff;

  // Timing at the core clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int DIR_SETUP_NS = 300;
  localparam int DIR_HOLD_NS = 75;
  localparam int BUSY_MAX_NS = 350;
  // Least times round up, longest time rounds down
  localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int DIR_HOLD_CYC = (DIR_HOLD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int BUSY_CYC_RAW = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int BUSY_CYC = (BUSY_CYC_RAW < 1) ? 1 : BUSY_CYC_RAW;

  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] SETUP_CNT = TMR_W'(DIR_SETUP_CYC);
  localparam logic [TMR_W-1:0] HOLD_CNT = TMR_W'(DIR_HOLD_CYC);
  localparam logic [TMR_W-1:0] BUSY_CNT = TMR_W'(BUSY_CYC);
  localparam logic [TMR_W-1:0] TMR_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_BUSY,
    ST_HOLD
  } step_state_type;

endpackage

// ---- step_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for one pin-level input
module step_sync
  import angle_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rst_val,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_ff <= rst_val;
      sync_out <= rst_val;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ---- tracking_angle_output_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module tracking_angle_output_port
  import angle_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Step requests from the loop oscillator (asynchronous pins)
  input wire logic step_up_req,
  input wire logic step_down_req,
  // Host hold, active low (asynchronous pin)
  input wire logic hold_n,
  // Host-facing outputs
  output logic [ANGLE_W-1:0] angle,
  output logic busy,
  output logic dir,
  output logic wrap_pulse_n
);

  logic up_s;
  logic down_s;
  logic hold_inv_s;
  logic up_d_ff;
  logic down_d_ff;
  logic up_pend_ff;
  logic down_pend_ff;
  step_state_type state_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic step_down_ff;
  logic hold_active;
  logic wrap_hit;
  logic [ANGLE_W-1:0] nxt_angle;

  step_sync u_sync_up (
    .core_clk(core_clk),
    .srst(srst),
    .rst_val(1'b0),
    .async_in(step_up_req),
    .sync_out(up_s)
  );

  step_sync u_sync_down (
    .core_clk(core_clk),
    .srst(srst),
    .rst_val(1'b0),
    .async_in(step_down_req),
    .sync_out(down_s)
  );

  // Inverted so the cleared synchroniser reads as "not holding"
  step_sync u_sync_hold (
    .core_clk(core_clk),
    .srst(srst),
    .rst_val(1'b0),
    .async_in(~hold_n),
    .sync_out(hold_inv_s)
  );

  assign hold_active = hold_inv_s;

  // Rising edges of the synchronised step requests
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      up_d_ff <= 1'b0;
      down_d_ff <= 1'b0;
    end
    else
    begin
      up_d_ff <= up_s;
      down_d_ff <= down_s;
    end
  end

  // Latch one pending step per direction; a new edge wins over consumption
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      up_pend_ff <= 1'b0;
      down_pend_ff <= 1'b0;
    end
    else
    begin
      if (up_s && !up_d_ff)
        up_pend_ff <= 1'b1;
      else if (state_ff == ST_IDLE && !hold_active && up_pend_ff)
        up_pend_ff <= 1'b0;
      if (down_s && !down_d_ff)
        down_pend_ff <= 1'b1;
      else if (state_ff == ST_IDLE && !hold_active && !up_pend_ff
               && down_pend_ff)
        down_pend_ff <= 1'b0;
    end
  end

  // Step sequencer: direction setup, busy pulse, direction hold.
  // Hold is only looked at in idle, so a running pulse always completes.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff <= ST_IDLE;
      tmr_ff <= TMR_RST;
      step_down_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (!hold_active && (up_pend_ff || down_pend_ff))
          begin
            state_ff <= ST_SETUP;
            tmr_ff <= SETUP_CNT;
            step_down_ff <= !up_pend_ff;
          end
        end
        ST_SETUP:
        begin
          if (tmr_ff == 8'h01)
          begin
            state_ff <= ST_BUSY;
            tmr_ff <= BUSY_CNT;
          end
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        ST_BUSY:
        begin
          if (tmr_ff == 8'h01)
          begin
            state_ff <= ST_HOLD;
            tmr_ff <= HOLD_CNT;
          end
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        ST_HOLD:
        begin
          if (tmr_ff == 8'h01)
            state_ff <= ST_IDLE;
          else
            tmr_ff <= tmr_ff - 8'h01;
        end
        default:
        begin
          state_ff <= ST_IDLE;
          tmr_ff <= TMR_RST;
        end
      endcase
    end
  end

  // Wraps modulo 4096 through natural overflow
  assign nxt_angle = step_down_ff ? angle - 12'h001 : angle + 12'h001;
  assign wrap_hit = step_down_ff ? (angle == ANGLE_RST)
                                 : (angle == ANGLE_ALL_ONES);

  // Counter steps once, at the rising edge of busy
  always_ff @(posedge core_clk)
  begin
    if (srst)
      angle <= ANGLE_RST;
    else if (state_ff == ST_SETUP && tmr_ff == 8'h01)
      angle <= nxt_angle;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      busy <= 1'b0;
    else
      busy <= (state_ff == ST_SETUP && tmr_ff == 8'h01)
           || (state_ff == ST_BUSY && tmr_ff != 8'h01);
  end

  // Direction held steady from setup through hold
  always_ff @(posedge core_clk)
  begin
    if (srst)
      dir <= 1'b0;
    else if (state_ff == ST_IDLE && !hold_active
             && (up_pend_ff || down_pend_ff))
      dir <= !up_pend_ff;
  end

  // Wrap pulse spans the busy period of the rollover step
  always_ff @(posedge core_clk)
  begin
    if (srst)
      wrap_pulse_n <= 1'b1;
    else if (state_ff == ST_SETUP && tmr_ff == 8'h01)
      wrap_pulse_n <= !wrap_hit;
    else if (state_ff == ST_BUSY && tmr_ff == 8'h01)
      wrap_pulse_n <= 1'b1;
  end

endmodule
`default_nettype wire

// ---- angle_port_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module angle_port_properties
  import angle_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Watched pins
  input wire logic hold_n,
  input wire logic [ANGLE_W-1:0] angle,
  input wire logic busy,
  input wire logic dir,
  input wire logic wrap_pulse_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_busy_len; $rose(busy) |-> ##42 busy ##1 !busy; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy width");
  property p_cause; $changed(angle) |-> $rose(busy); endproperty
  a_cause: assert property (p_cause) else $error("stray step");
  property p_val;
    $rose(busy) |-> angle == $past(angle) + (dir ? 12'hfff : 12'h001);
  endproperty
  a_val: assert property (p_val) else $error("step value");
  property p_setup; $rose(busy) |-> $past(dir, 38) == dir; endproperty
  a_setup: assert property (p_setup) else $error("dir setup");
  // Ten cycles past the rising busy edge, all inside busy; the 75 ns hold after busy falls is not covered
  property p_dhold;
    $rose(busy) |=> $stable(dir)[*8] ##1 $stable(dir)[*2];
  endproperty
  a_dhold: assert property (p_dhold) else $error("dir hold");
  property p_wrap;
    $rose(busy) |->
      (!wrap_pulse_n == (angle == (dir ? ANGLE_ALL_ONES : ANGLE_RST)));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap edge");
  property p_span; !wrap_pulse_n |-> busy; endproperty
  a_span: assert property (p_span) else $error("wrap span");
  property p_hold;
    $rose(busy) |->
      $past(hold_n, 40) || $past(hold_n, 41) || $past(hold_n, 42);
  endproperty
  a_hold: assert property (p_hold) else $error("held step");
endmodule
bind tracking_angle_output_port angle_port_properties angle_port_properties_i
(
  .core_clk(core_clk),
  .srst(srst),
  .hold_n(hold_n),
  .angle(angle),
  .busy(busy),
  .dir(dir),
  .wrap_pulse_n(wrap_pulse_n)
);
`default_nettype wire

// ---- angle_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module angle_host_model
  import angle_port_pkg::*;
(
  // Clock, reset, datum switch
  input wire logic core_clk,
  input wire logic srst,
  input wire logic datum_n,
  // Converter pins
  input wire logic [ANGLE_W-1:0] angle,
  input wire logic busy,
  input wire logic dir,
  input wire logic wrap_pulse_n,
  // Host view
  output logic [ANGLE_W-1:0] word_ff,
  output logic [ANGLE_W-1:0] revs_ff
);
  logic busy_ff;
  logic wrap_ff;
  always_ff @(posedge core_clk)
  begin
    busy_ff <= busy;
    wrap_ff <= wrap_pulse_n;
  end
  always_ff @(posedge core_clk)
    if (srst)
      word_ff <= ANGLE_RST;
    else if (busy_ff && !busy)
      word_ff <= angle;
  // Trailing edge of wrap, so dir has stood all pulse long
  always_ff @(posedge core_clk)
    if (srst || !datum_n)
      revs_ff <= 12'h000;
    else if (!wrap_ff && wrap_pulse_n)
      revs_ff <= revs_ff + (dir ? 12'hfff : 12'h001);
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import angle_port_pkg::*;
  logic core_clk, srst, step_up_req, step_down_req, hold_n, datum_n;
  logic busy, dir, wrap_pulse_n;
  logic [ANGLE_W-1:0] angle, word, revs;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  tracking_angle_output_port tracking_angle_output_port_i (
    .core_clk(core_clk), .srst(srst), .step_up_req(step_up_req),
    .step_down_req(step_down_req), .hold_n(hold_n), .angle(angle),
    .busy(busy), .dir(dir), .wrap_pulse_n(wrap_pulse_n));
  angle_host_model angle_host_model_i (
    .core_clk(core_clk), .srst(srst), .datum_n(datum_n), .angle(angle),
    .busy(busy), .dir(dir), .wrap_pulse_n(wrap_pulse_n),
    .word_ff(word), .revs_ff(revs));
  initial
  begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      final_report;
    end
  end
  task automatic chk(input logic [ANGLE_W-1:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input logic down);
    step_down_req = down;
    step_up_req = !down;
    tick(4);
    step_down_req = 0;
    step_up_req = 0;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 300 && busy !== lvl; i++)
      tick(1);
    if (busy !== lvl)
    begin
      errors++;
      $display("BAD %0t busy stuck", $time);
    end
  endtask
  task automatic done;
    wait_busy(1);
    wait_busy(0);
    tick(12);
  endtask
  initial
  begin
    srst = 1;
    step_up_req = 0;
    step_down_req = 0;
    hold_n = 1;
    datum_n = 1;
    tick(5);
    srst = 0;
    tick(2);
    chk(angle, ANGLE_RST);
    pulse(1);
    done;
    chk(word, 12'hfff);
    chk(12'(dir), 12'h001);
    chk(revs, 12'hfff);
    datum_n = 0;
    tick(1);
    datum_n = 1;
    chk(revs, 12'h000);
    pulse(0);
    done;
    chk(word, 12'h000);
    chk(12'(dir), 12'h000);
    chk(revs, 12'h001);
    for (int k = 1; k < 4; k++)
    begin
      pulse(0);
      done;
      chk(word, 12'(k));
    end
    // Hold first, then ask: the step must wait for release
    hold_n = 0;
    pulse(0);
    tick(150);
    chk(angle, 12'h003);
    hold_n = 1;
    done;
    chk(word, 12'h004);
    pulse(1);
    wait_busy(1);
    hold_n = 0;
    wait_busy(0);
    tick(2);
    chk(word, 12'h003);
    pulse(0);
    tick(120);
    chk(angle, 12'h003);
    hold_n = 1;
    done;
    chk(word, 12'h004);
    final_report;
  end
endmodule
`default_nettype wire
